// file: inc/pidlc_params.svh
// Constants of the loop regulator: register offsets, codes, defaults, scaling.
// Assumes parameters arrive as fixed-point words from the parameter store.
`ifndef PIDLC_PARAMS_SVH
`define PIDLC_PARAMS_SVH
`define PIDLC_OFS_TARGET     4'h6
`define PIDLC_OFS_CMD        4'hf
`define PIDLC_CMD_TGT_BIT    1
`define PIDLC_FN_FEEDBACK    4'h8
`define PIDLC_FN_TARGET      4'h9
`define PIDLC_FN_DIFF        4'ha
`define PIDLC_PFN_FEEDBACK   4'h1
`define PIDLC_PFN_TARGET     4'h2
`define PIDLC_GAIN_ONE       16'sh0064
`define PIDLC_ITIME_DEF      16'h000a
`define PIDLC_PCT_FULL       16'sh03e8
`define PIDLC_FULL_SCALE     32'sh00002710
`define PIDLC_TICK_NS        1000000
`define PIDLC_CLK_NS         8
`define PIDLC_TICK_CYC       (`PIDLC_TICK_NS / `PIDLC_CLK_NS)
`define PIDLC_TICK_PER_SEC   1000
`endif

// file: inc/pidlc_pkg.sv
// Types of the loop regulator: modes, settings and status carriers.
// Assumes pidlc_params.svh sits on the include path.
package pidlc_pkg;
  typedef enum logic [2:0] {
    PIDLC_OFF, PIDLC_M1, PIDLC_M2, PIDLC_M3, PIDLC_M4
  } pidlc_mode_t;
  typedef struct packed {
    logic [2:0]         loop_mode;          // 0..4
    logic signed [15:0] proportional_gain;  // 0.01 units
    logic [15:0]        integral_time;      // 0.1 s units
    logic signed [15:0] integral_clamp;     // 0.1 %
    logic [15:0]        derivative_time;    // 0.01 s units
    logic signed [15:0] output_upper_limit; // 0.1 %
    logic signed [15:0] output_bias;        // 0.1 %
    logic [15:0]        output_filter_time; // 0.01 s units
    logic               output_sign_invert;
    logic signed [15:0] output_gain;        // 0.01 units
    logic               reverse_permit;
    logic               stored_target_enable;
    logic signed [15:0] stored_target_value; // 0.01 %
    logic [3:0]         analog_one_function;
    logic [3:0]         analog_two_function;
    logic [3:0]         pulse_input_function;
  } pidlc_cfg_t;
  typedef struct packed {
    logic               target_conflict_fault;
    logic               feedback_conflict_fault;
    logic               loop_active;
    logic               reverse_run;
    logic signed [15:0] deviation_monitor;
    logic signed [15:0] feedback_monitor;
  } pidlc_stat_t;
endpackage : pidlc_pkg

// file: verilog/pidlc_tick.sv
// Sample tick generator: one-cycle pulse every fixed interval.
// Assumes mclk at 125 MHz.
`timescale 1ns/1ps
`include "pidlc_params.svh"
module pidlc_tick #(
  parameter int unsigned PERIOD = `PIDLC_TICK_CYC
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Tick out
  output logic      tick
);
  logic [31:0] cnt_q, cnt_d; // Cycle counter
  // Next count, wrap at period
  always_comb begin
    tick  = (cnt_q == PERIOD - 1);
    cnt_d = tick ? 32'h0 : cnt_q + 32'h1;
  end
  // Register count
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : pidlc_tick

// file: verilog/pidlc_sync.sv
// Two-stage synchroniser for a word from outside the clock domain.
// Assumes the word changes slowly relative to mclk (sensor samples).
`timescale 1ns/1ps
module pidlc_sync #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_q, s2_q; // Stages
  // Two flops, first read only by second
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
    end
  end
  assign dout = s2_q;
endmodule : pidlc_sync

// file: verilog/pidlc_core.sv
// Closed-loop regulator: source select, conflict check, PID terms, output chain.
// Assumes sensor words arrive asynchronously; settings and serial registers
// come from the same clock domain. Values are signed, 10000 = full scale.
`timescale 1ns/1ps
`include "pidlc_params.svh"
// Operation
// R1: Target priority A1, A2, pulse, stored, serial
// R2: Serial target used when command bit set
// R3: Both analog targets raise target conflict
// R4: Single feedback source; more raise conflict
// R5: Code 10 enables differential feedback
// R6: Two differential inputs raise feedback conflict
// R7: Mode zero disables, one to four enable
// R8: Derivative on deviation or feedback by mode
// R9: Modes three, four add frequency command
// R10: Proportional gain scales deviation
// R11: Integral time; zero disables integral
// R12: Integral term clamped to limit
// R13: Derivative time; zero disables derivative
// R14: Output clamped to upper limit
// R15: Signed bias added to output
// R16: First-order output filter; zero bypasses
// R17: Sign select inverts output
// R18: Output gain multiplies output
// R19: Reverse permit: clamp negative or reverse
// R20: Modes three, four ignore reverse permit
// R21: Evaluate chain once per sample tick
// R22: Check conflicts on code change; hold disabled
module pidlc_core
  import pidlc_pkg::*;
#(
  parameter int unsigned TICK_CYC = `PIDLC_TICK_CYC // Cycles per sample tick
) (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rst_n,
  // Sensor inputs (asynchronous)
  input  wire logic signed [15:0] analog_input_one,
  input  wire logic signed [15:0] analog_input_two,
  input  wire logic signed [15:0] pulse_train_input,
  // Settings
  input  pidlc_pkg::pidlc_cfg_t   cfg,
  // Serial register port
  input  wire logic               reg_we,
  input  wire logic [3:0]         reg_addr,
  input  wire logic [15:0]        reg_wdata,
  output logic      [15:0]        reg_rdata,
  // Frequency path
  input  wire logic signed [15:0] freq_command,
  output logic signed [15:0]      freq_demand,
  output pidlc_pkg::pidlc_stat_t  stat
);
  import pidlc_pkg::*;

  logic signed [15:0] a1_s, a2_s, rp_s;         // Synchronised sensors
  logic               tick;                     // Sample tick
  logic [15:0]        tgt_q, tgt_d;             // Serial target register
  logic [15:0]        cmd_q, cmd_d;             // Serial command register
  logic signed [15:0] target, fb;               // Selected values
  logic               tgt_ok;                   // Some target assigned
  logic [1:0]         n_fb, n_diff;             // Assignment counts
  logic               tconf_q, tconf_d;         // Target conflict
  logic               fconf_q, fconf_d;         // Feedback conflict
  logic [11:0]        codes_q;                  // Last seen function codes
  logic signed [31:0] integ_q, integ_d;         // Integral accumulator
  logic signed [15:0] dsrc_q, dsrc_d;           // Previous derivative source
  logic signed [31:0] filt_q, filt_d;           // Filter state
  logic signed [15:0] dem_q, dem_d;             // Demand output
  logic               rev_q, rev_d;             // Reverse run flag
  logic signed [15:0] dev_q, dev_d, fbm_q, fbm_d; // Monitors
  pidlc_mode_t        mode;                     // Decoded mode
  logic               active;                   // Loop running

  // Sensor synchronisers
  pidlc_sync #(.W(16)) u_sa1 (.mclk(mclk), .rst_n(rst_n), .din(analog_input_one),
                              .dout(a1_s));
  pidlc_sync #(.W(16)) u_sa2 (.mclk(mclk), .rst_n(rst_n), .din(analog_input_two),
                              .dout(a2_s));
  pidlc_sync #(.W(16)) u_srp (.mclk(mclk), .rst_n(rst_n), .din(pulse_train_input),
                              .dout(rp_s));
  // Sample tick
  pidlc_tick #(.PERIOD(TICK_CYC)) u_tick (.mclk(mclk), .rst_n(rst_n), .tick(tick));

  // Serial register writes and reads
  always_comb begin
    tgt_d = tgt_q;
    cmd_d = cmd_q;
    if (reg_we && reg_addr == `PIDLC_OFS_TARGET) begin
      tgt_d = reg_wdata; // R2
    end
    if (reg_we && reg_addr == `PIDLC_OFS_CMD) begin
      cmd_d = reg_wdata; // R2
    end
    unique case (reg_addr)
      `PIDLC_OFS_TARGET: reg_rdata = tgt_q;
      `PIDLC_OFS_CMD:    reg_rdata = cmd_q;
      default:           reg_rdata = 16'h0000; // Unmapped reads zero
    endcase
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tgt_q <= 16'h0000;
      cmd_q <= 16'h0000;
    end else begin
      tgt_q <= tgt_d;
      cmd_q <= cmd_d;
    end
  end

  // Source selection by priority
  always_comb begin
    tgt_ok = 1'b1;
    if (cfg.analog_one_function == `PIDLC_FN_TARGET) begin
      target = a1_s; // R1
    end else if (cfg.analog_two_function == `PIDLC_FN_TARGET) begin
      target = a2_s; // R1
    end else if (cfg.pulse_input_function == `PIDLC_PFN_TARGET) begin
      target = rp_s; // R1
    end else if (cfg.stored_target_enable) begin
      target = cfg.stored_target_value; // R1
    end else if (cmd_q[`PIDLC_CMD_TGT_BIT]) begin
      target = $signed(tgt_q); // R2
    end else begin
      target = 16'sh0000;
      tgt_ok = 1'b0;
    end
    // Feedback source and counts
    n_fb = {1'b0, cfg.analog_one_function == `PIDLC_FN_FEEDBACK}
         + {1'b0, cfg.analog_two_function == `PIDLC_FN_FEEDBACK}
         + {1'b0, cfg.pulse_input_function == `PIDLC_PFN_FEEDBACK};
    n_diff = {1'b0, cfg.analog_one_function == `PIDLC_FN_DIFF}
           + {1'b0, cfg.analog_two_function == `PIDLC_FN_DIFF};
    if (cfg.analog_one_function == `PIDLC_FN_FEEDBACK) begin
      fb = a1_s; // R4
    end else if (cfg.analog_two_function == `PIDLC_FN_FEEDBACK) begin
      fb = a2_s; // R4
    end else if (cfg.pulse_input_function == `PIDLC_PFN_FEEDBACK) begin
      fb = rp_s; // R4
    end else begin
      fb = 16'sh0000;
    end
    // Differential feedback subtracts the analog input coded 10, first A1 then A2
    if (cfg.analog_one_function == `PIDLC_FN_DIFF) begin
      fb = 16'(fb - a1_s); // R5
    end else if (cfg.analog_two_function == `PIDLC_FN_DIFF) begin
      fb = 16'(fb - a2_s); // R5
    end
  end

  // Conflict check, re-evaluated when any function code changes
  always_comb begin
    tconf_d = tconf_q;
    fconf_d = fconf_q;
    if ({cfg.analog_one_function, cfg.analog_two_function,
         cfg.pulse_input_function} != codes_q) begin // R22
      tconf_d = (cfg.analog_one_function == `PIDLC_FN_TARGET) &&
                (cfg.analog_two_function == `PIDLC_FN_TARGET); // R3
      fconf_d = (n_fb > 2'd1) || (n_diff > 2'd1); // R4 R6
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tconf_q <= 1'b0;
      fconf_q <= 1'b0;
      codes_q <= 12'h000;
    end else begin
      tconf_q <= tconf_d;
      fconf_q <= fconf_d;
      codes_q <= {cfg.analog_one_function, cfg.analog_two_function,
                  cfg.pulse_input_function};
    end
  end

  assign mode   = (cfg.loop_mode > 3'd4) ? PIDLC_OFF : pidlc_mode_t'(cfg.loop_mode);
  assign active = (mode != PIDLC_OFF) && !tconf_q && !fconf_q; // R7 R22

  // Per-tick computation of the whole output chain
  always_comb begin
    logic signed [31:0] dev, pterm, dterm, isum, lim, sum, x, y, ilim;
    logic signed [15:0] dsrc;
    logic               addcmd, dev_mode;
    {isum, dterm, x} = '0; // Known values ahead of the branches
    dev      = 32'(target) - 32'(fb);
    addcmd   = (mode == PIDLC_M3) || (mode == PIDLC_M4);
    dev_mode = (mode == PIDLC_M1) || (mode == PIDLC_M3);
    dsrc     = dev_mode ? 16'(dev) : fb; // R8
    ilim     = 32'(cfg.integral_clamp) * 32'sd10; // R12
    pterm    = (dev * 32'(cfg.proportional_gain)) / 32'(`PIDLC_GAIN_ONE); // R10
    // Integral: add dev/(Ti*ticks per second) each tick
    if (cfg.integral_time == 16'h0000) begin
      isum = 32'sh0; // R11
    end else begin
      isum = integ_q + (dev * 32'sd10) /
             (32'($signed({1'b0, cfg.integral_time})) * 32'(`PIDLC_TICK_PER_SEC)); // R11
    end
    if (isum > ilim) isum = ilim; // R12
    if (isum < -ilim) isum = -ilim; // R12
    // Derivative: Td * slope; deviation or negated feedback
    if (cfg.derivative_time == 16'h0000) begin
      dterm = 32'sh0; // R13
    end else begin
      dterm = ((32'(dsrc) - 32'(dsrc_q)) *
               32'($signed({1'b0, cfg.derivative_time})) * 32'(`PIDLC_TICK_PER_SEC))
              / 32'sd100; // R13
      if (!dev_mode) dterm = -dterm; // R8
    end
    sum = pterm + isum + dterm; // R21
    lim = 32'(cfg.output_upper_limit) * 32'sd10; // R14
    if (sum > lim) sum = lim; // R14
    if (sum < -lim) sum = -lim; // R14
    sum = sum + 32'(cfg.output_bias) * 32'sd10; // R15
    // First-order lag: y += (x - y) / (1 + tau*ticks)
    if (cfg.output_filter_time == 16'h0000) begin
      x = sum; // R16
    end else begin
      x = filt_q + (sum - filt_q) /
          (32'sd1 + 32'($signed({1'b0, cfg.output_filter_time})) *
           32'(`PIDLC_TICK_PER_SEC) / 32'sd100); // R16
    end
    y = cfg.output_sign_invert ? -x : x; // R17
    y = (y * 32'(cfg.output_gain)) / 32'(`PIDLC_GAIN_ONE); // R18
    if (addcmd) y = y + 32'(freq_command); // R9
    rev_d = rev_q;
    // Negative output handling
    if (!addcmd && y < 0) begin
      if (!cfg.reverse_permit) begin
        y     = 32'sh0; // R19
        rev_d = 1'b0;
      end else begin
        rev_d = 1'b1; // R19
      end
    end else if (!addcmd) begin
      rev_d = 1'b0;
    end else begin
      rev_d = 1'b0; // R20
    end
    if (y > `PIDLC_FULL_SCALE) y = `PIDLC_FULL_SCALE;
    if (y < -`PIDLC_FULL_SCALE) y = -`PIDLC_FULL_SCALE;
    // Defaults hold between ticks
    integ_d = integ_q;
    dsrc_d  = dsrc_q;
    filt_d  = filt_q;
    dem_d   = dem_q;
    dev_d   = dev_q;
    fbm_d   = fbm_q;
    if (tick) begin // R21
      dev_d = 16'(dev);
      fbm_d = fb;
      if (active) begin
        integ_d = isum;
        dsrc_d  = dsrc;
        filt_d  = x;
        dem_d   = 16'(y);
      end else begin
        integ_d = 32'sh0; // R7
        dsrc_d  = dsrc;
        filt_d  = 32'sh0;
        dem_d   = freq_command; // R7
        rev_d   = 1'b0;
      end
    end else begin
      rev_d = rev_q;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      integ_q <= 32'sh0;
      dsrc_q  <= 16'sh0;
      filt_q  <= 32'sh0;
      dem_q   <= 16'sh0;
      rev_q   <= 1'b0;
      dev_q   <= 16'sh0;
      fbm_q   <= 16'sh0;
    end else begin
      integ_q <= integ_d;
      dsrc_q  <= dsrc_d;
      filt_q  <= filt_d;
      dem_q   <= dem_d;
      rev_q   <= rev_d;
      dev_q   <= dev_d;
      fbm_q   <= fbm_d;
    end
  end

  // Outputs
  assign freq_demand                  = dem_q;
  assign stat.target_conflict_fault   = tconf_q;
  assign stat.feedback_conflict_fault = fconf_q;
  assign stat.loop_active             = active && tgt_ok;
  assign stat.reverse_run             = rev_q;
  assign stat.deviation_monitor       = dev_q;
  assign stat.feedback_monitor        = fbm_q;
endmodule : pidlc_core

// file: verif/pidlc_far_side.sv
// Far-side model: sensor words and a serial register master for the regulator.
// Assumes one clock; the bench calls its tasks to drive the block.
`timescale 1ns/1ps
module pidlc_far_side (
  // Clock
  input  wire logic         mclk,
  // Serial register master
  output logic              reg_we,
  output logic [3:0]        reg_addr,
  output logic [15:0]       reg_wdata,
  // Sensor words
  output logic signed [15:0] analog_input_one,
  output logic signed [15:0] analog_input_two,
  output logic signed [15:0] pulse_train_input
);
  // Idle values at time zero
  initial begin
    reg_we            = 1'b0;
    reg_addr          = 4'h0;
    reg_wdata         = 16'h0000;
    analog_input_one  = 16'sh0000;
    analog_input_two  = 16'sh0000;
    pulse_train_input = 16'sh0000;
  end

  // One write: held to the taking edge, then data scrambled once released
  task automatic write_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_we    <= 1'b0;
    reg_wdata <= ~d;
  endtask : write_reg

  // Points the combinational read at one address
  task automatic point(input logic [3:0] a);
    @(posedge mclk);
    reg_addr <= a;
  endtask : point

  // New sensor samples
  task automatic set_sensors(input logic [15:0] s1, input logic [15:0] s2, input logic [15:0] sp);
    @(posedge mclk);
    analog_input_one  <= s1;
    analog_input_two  <= s2;
    pulse_train_input <= sp;
  endtask : set_sensors
endmodule : pidlc_far_side

// file: verif/pidlc_core_props.sv
// Checker of the regulator: conflict flags, enable, demand sign, register port.
// Assumes binding to pidlc_core; codes 8, 9, 10 and pulse 1 as in settings.
`timescale 1ns/1ps
module pidlc_core_props
  import pidlc_pkg::*;
(
  // Clock and reset
  input wire logic              mclk,
  input wire logic              rst_n,
  // Settings and register port
  input pidlc_pkg::pidlc_cfg_t  cfg,
  input wire logic              reg_we,
  input wire logic [3:0]        reg_addr,
  input wire logic [15:0]       reg_wdata,
  input wire logic [15:0]       reg_rdata,
  // Frequency path
  input wire logic signed [15:0] freq_command,
  input wire logic signed [15:0] freq_demand,
  input pidlc_pkg::pidlc_stat_t stat
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Both analog inputs claim the target
  wire tgt_bad = cfg.analog_one_function == 4'h9 && cfg.analog_two_function == 4'h9;
  // More than one feedback, or two differential feedbacks
  wire [1:0] n_fb = 2'(cfg.analog_one_function == 4'h8) + 2'(cfg.analog_two_function == 4'h8)
                  + 2'(cfg.pulse_input_function == 4'h1);
  wire fb_bad = n_fb > 2'h1 || (cfg.analog_one_function == 4'ha && cfg.analog_two_function == 4'ha);
  wire mapped = reg_addr == 4'h6 || reg_addr == 4'hf;

  AST_TGT_SET: assert property (tgt_bad [*3] |-> stat.target_conflict_fault)
    else $error("target conflict not raised");
  AST_TGT_CLR: assert property (!tgt_bad [*3] |-> !stat.target_conflict_fault)
    else $error("target conflict without cause");
  AST_FB_SET: assert property (fb_bad [*3] |-> stat.feedback_conflict_fault)
    else $error("feedback conflict not raised");
  AST_FB_CLR: assert property (!fb_bad [*3] |-> !stat.feedback_conflict_fault)
    else $error("feedback conflict without cause");
  AST_ACTIVE: assert property (stat.loop_active |-> cfg.loop_mode inside {[3'h1:3'h4]}
    && !stat.target_conflict_fault && !stat.feedback_conflict_fault)
    else $error("loop active while off or faulted");
  AST_OFF_PASS: assert property (($changed(freq_demand) && $past(cfg.loop_mode) == 3'h0
    && $stable(freq_command)) |-> freq_demand == freq_command)
    else $error("disabled loop did not pass command");
  AST_NO_NEG: assert property (($changed(freq_demand) && $past(cfg.loop_mode) inside {3'h1, 3'h2}
    && !$past(cfg.reverse_permit)) |-> !freq_demand[15])
    else $error("negative demand without permit");
  AST_REV_RUN: assert property ($rose(stat.reverse_run) |-> $past(cfg.reverse_permit)
    && $past(cfg.loop_mode) inside {3'h1, 3'h2})
    else $error("reverse run not allowed here");
  AST_READBACK: assert property ((reg_we && mapped) ##1 (reg_addr == $past(reg_addr))
    |-> reg_rdata == $past(reg_wdata))
    else $error("register did not keep written word");
  AST_UNMAPPED: assert property (!mapped |-> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
endmodule : pidlc_core_props

bind pidlc_core pidlc_core_props u_props (.mclk, .rst_n, .cfg, .reg_we, .reg_addr, .reg_wdata,
  .reg_rdata, .freq_command, .freq_demand, .stat);

// file: verif/pidlc_core_tb.sv
// Self-checking bench of the regulator: registers, conflict table, four sample tick cases.
// Assumes a short sample tick set at the instance; each tick case waits two ticks.
`timescale 1ns/1ps
module pidlc_core_tb;
  import pidlc_pkg::*;
  localparam logic [3:0] FN [4] = '{4'h0, 4'h8, 4'h9, 4'ha}; // Analog codes walked
  localparam int         TICK   = 1000; // Sample tick of the run, in cycles
  logic               mclk, rst_n, reg_we, tc, fc, act;
  logic [3:0]         reg_addr;
  logic [15:0]        reg_wdata, reg_rdata;
  logic signed [15:0] freq_command, freq_demand, a_one, a_two, pulse;
  pidlc_cfg_t         cfg;
  pidlc_stat_t        stat;
  int                 error_cnt, n_compared, seed, i, n8;
  int                 reg_model [16]; // Expected register contents

  pidlc_far_side far (.mclk(mclk), .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .analog_input_one(a_one), .analog_input_two(a_two), .pulse_train_input(pulse));
  pidlc_core #(.TICK_CYC(TICK)) dut (.mclk(mclk), .rst_n(rst_n), .analog_input_one(a_one),
    .analog_input_two(a_two),
    .pulse_train_input(pulse), .cfg(cfg), .reg_we(reg_we), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .freq_command(freq_command),
    .freq_demand(freq_demand), .stat(stat));

  // Clock of 8 ns
  always #4 mclk = ~mclk;

  // One comparison against the model
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Verdict and end of run
  task automatic complete_run;
    $display("errors %0d comparisons %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // One tick case: new settings and sensors, two ticks, then the chain is checked with integral, derivative and filter off
  task automatic tick_case(input int md, input int inv, input int gain, input int bias,
                           input int permit, input int cmd, input int stv, input int fbv);
    int dv, y;
    far.set_sensors(16'(fbv), 16'($random(seed)), 16'($random(seed)));
    freq_command <= 16'(cmd);
    cfg <= '{loop_mode: 3'(md), proportional_gain: 16'sh0064, integral_clamp: 16'sh03e8,
             output_upper_limit: 16'sh03e8, output_bias: 16'(bias),
             output_sign_invert: 1'(inv), output_gain: 16'(gain), reverse_permit: 1'(permit),
             stored_target_enable: 1'b1, stored_target_value: 16'(stv),
             analog_one_function: 4'h8, default: '0};
    repeat (2 * TICK) @(posedge mclk);
    @(negedge mclk);
    // Model: term sum at gain 1.00, limit 100%, bias, sign, gain, command, reverse
    dv = stv - fbv;
    y = dv > 10000 ? 10000 : (dv < -10000 ? -10000 : dv);
    y = (inv ? -(y + bias * 10) : y + bias * 10) * gain / 100;
    if (md >= 3) y = y + cmd;
    else if (y < 0 && permit == 0) y = 0;
    y = y > 10000 ? 10000 : (y < -10000 ? -10000 : y);
    if (md == 0) y = cmd;
    chk(freq_demand, 16'(y));
    chk(stat.deviation_monitor, 16'(dv));
    chk(stat.feedback_monitor, 16'(fbv));
    chk({15'h0000, stat.reverse_run},
        {15'h0000, ((md == 1 || md == 2) && permit != 0 && y < 0)});
  endtask : tick_case

  // Watchdog well beyond the four tick cases
  initial begin
    #(8 * (300 + 10 * TICK));
    error_cnt++;
    complete_run();
  end

  // Main sequence
  initial begin
    seed = 82;
    mclk = 1'b0;
    rst_n = 1'b0;
    cfg = '0;
    freq_command = 16'sh0000;
    foreach (reg_model[j]) reg_model[j] = 0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    // Registers, an unmapped one among them
    reg_model[6] = $random(seed) & 32'h0000ffff;
    reg_model[15] = 2;
    far.write_reg(4'h6, 16'(reg_model[6]));
    far.write_reg(4'hf, 16'h0002);
    far.write_reg(4'h3, 16'hbeef);
    for (i = 0; i < 16; i++) begin
      far.point(4'(i));
      @(negedge mclk);
      chk(reg_rdata, 16'(reg_model[i]));
    end
    // Every pairing of analog codes, pulse codes 0 to 2, modes 0 to 7
    for (i = 0; i < 48; i++) begin
      @(posedge mclk);
      cfg.analog_one_function <= FN[i % 4];
      cfg.analog_two_function <= FN[(i / 4) % 4];
      cfg.pulse_input_function <= 4'(i / 16);
      cfg.loop_mode <= 3'(i % 8);
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      tc = FN[i % 4] == 4'h9 && FN[(i / 4) % 4] == 4'h9;
      n8 = int'(FN[i % 4] == 4'h8) + int'(FN[(i / 4) % 4] == 4'h8) + int'(i / 16 == 1);
      fc = n8 > 1 || (FN[i % 4] == 4'ha && FN[(i / 4) % 4] == 4'ha);
      act = (i % 8) inside {[1:4]} && !tc && !fc;
      chk({13'h0000, stat.target_conflict_fault, stat.feedback_conflict_fault, stat.loop_active},
          {13'h0000, tc, fc, act});
    end
    // Mode 3, inverted sign, gain 2.00, stored target over the serial one
    tick_case(3, 1, 200, 0, 0, 4000, 5000, 2000);
    // Mode 1 with bias, negative result clamped without permit
    tick_case(1, 0, 100, 100, 0, 0, 2000, 5000);
    // Mode 2 with permit: negative demand and reverse run
    tick_case(2, 0, 150, 0, 1, 0, 1000, 3000);
    // Mode 0 passes the ordinary command
    tick_case(0, 0, 100, 0, 0, 1234, 3000, 1000);
    complete_run();
  end
endmodule : pidlc_core_tb
